// *** logic/ifeb_pkg.sv ***
`default_nettype none

package ifeb_pkg;

    // Common carriers
    typedef logic [15:0] ifeb_word_type;
    typedef logic [2:0] ifeb_addr_type;

    // Register offsets on the local register port
    localparam ifeb_addr_type ADDR_FLAGS_2 = 3'h0;
    localparam ifeb_addr_type ADDR_FLAGS_3 = 3'h1;
    localparam ifeb_addr_type ADDR_FLAGS_4 = 3'h2;
    localparam ifeb_addr_type ADDR_ENABLES_0 = 3'h3;
    localparam ifeb_addr_type ADDR_ENABLES_1 = 3'h4;
    localparam ifeb_addr_type ADDR_ENABLES_2 = 3'h5;
    localparam ifeb_addr_type ADDR_ENABLES_3 = 3'h6;

    // Every register clears at power-on
    localparam ifeb_word_type REG_RESET = 16'h0000;
    localparam ifeb_word_type WORD_ZERO = 16'h0000;
    localparam ifeb_word_type ONE_BIT = 16'h0001;

    // Flag bank 2; its enable bank 2 uses the same positions
    localparam int PARALLEL_PORT_FLAG = 13;
    localparam int COMPARE5_FLAG = 9;
    localparam int CAPTURE5_FLAG = 7;
    localparam int CAPTURE4_FLAG = 6;
    localparam int CAPTURE3_FLAG = 5;
    localparam int SERIAL_PERIPH2_EVENT_FLAG = 1;
    localparam int SERIAL_PERIPH2_FAULT_FLAG = 0;

    // Flag bank 3; its enable bank 3 uses the same positions
    localparam int CALENDAR_ALARM_FLAG = 14;
    localparam int EXT_PIN4_FLAG = 6;
    localparam int EXT_PIN3_FLAG = 5;
    localparam int I2C2_MASTER_FLAG = 2;
    localparam int I2C2_SLAVE_FLAG = 1;

    // Flag bank 4
    localparam int CRC_DONE_FLAG = 3;
    localparam int UART2_ERROR_FLAG = 2;
    localparam int UART1_ERROR_FLAG = 1;

    // Enable bank 0
    localparam int ADC_DONE_ENABLE = 13;
    localparam int UART1_TRANSMIT_ENABLE = 12;
    localparam int UART1_RECEIVE_ENABLE = 11;
    localparam int SERIAL_PERIPH1_EVENT_ENABLE = 10;
    localparam int SERIAL_PERIPH1_FAULT_ENABLE = 9;
    localparam int TIMER3_ENABLE = 8;
    localparam int TIMER2_ENABLE = 7;
    localparam int COMPARE2_ENABLE = 6;
    localparam int CAPTURE2_ENABLE = 5;
    localparam int TIMER1_ENABLE = 3;
    localparam int COMPARE1_ENABLE = 2;
    localparam int CAPTURE1_ENABLE = 1;
    localparam int EXT_PIN0_ENABLE = 0;

    // Enable bank 1
    localparam int UART2_TRANSMIT_ENABLE = 15;
    localparam int UART2_RECEIVE_ENABLE = 14;
    localparam int EXT_PIN2_ENABLE = 13;
    localparam int TIMER5_ENABLE = 12;
    localparam int TIMER4_ENABLE = 11;
    localparam int COMPARE4_ENABLE = 10;
    localparam int COMPARE3_ENABLE = 9;
    localparam int EXT_PIN1_ENABLE = 4;
    localparam int CHANGE_NOTIFY_ENABLE = 3;
    localparam int COMPARATOR_ENABLE = 2;
    localparam int I2C1_MASTER_ENABLE = 1;
    localparam int I2C1_SLAVE_ENABLE = 0;

    // Implemented-bit masks per register
    localparam ifeb_word_type FLAGS_2_MASK = (ONE_BIT << PARALLEL_PORT_FLAG)
        | (ONE_BIT << COMPARE5_FLAG) | (ONE_BIT << CAPTURE5_FLAG)
        | (ONE_BIT << CAPTURE4_FLAG) | (ONE_BIT << CAPTURE3_FLAG)
        | (ONE_BIT << SERIAL_PERIPH2_EVENT_FLAG) | (ONE_BIT << SERIAL_PERIPH2_FAULT_FLAG);
    localparam ifeb_word_type FLAGS_3_MASK = (ONE_BIT << CALENDAR_ALARM_FLAG)
        | (ONE_BIT << EXT_PIN4_FLAG) | (ONE_BIT << EXT_PIN3_FLAG)
        | (ONE_BIT << I2C2_MASTER_FLAG) | (ONE_BIT << I2C2_SLAVE_FLAG);
    localparam ifeb_word_type FLAGS_4_MASK = (ONE_BIT << CRC_DONE_FLAG)
        | (ONE_BIT << UART2_ERROR_FLAG) | (ONE_BIT << UART1_ERROR_FLAG);
    localparam ifeb_word_type ENABLES_0_MASK = (ONE_BIT << ADC_DONE_ENABLE)
        | (ONE_BIT << UART1_TRANSMIT_ENABLE) | (ONE_BIT << UART1_RECEIVE_ENABLE)
        | (ONE_BIT << SERIAL_PERIPH1_EVENT_ENABLE) | (ONE_BIT << SERIAL_PERIPH1_FAULT_ENABLE)
        | (ONE_BIT << TIMER3_ENABLE) | (ONE_BIT << TIMER2_ENABLE)
        | (ONE_BIT << COMPARE2_ENABLE) | (ONE_BIT << CAPTURE2_ENABLE)
        | (ONE_BIT << TIMER1_ENABLE) | (ONE_BIT << COMPARE1_ENABLE)
        | (ONE_BIT << CAPTURE1_ENABLE) | (ONE_BIT << EXT_PIN0_ENABLE);
    localparam ifeb_word_type ENABLES_1_HIGH_MASK = (ONE_BIT << UART2_TRANSMIT_ENABLE)
        | (ONE_BIT << UART2_RECEIVE_ENABLE) | (ONE_BIT << EXT_PIN2_ENABLE)
        | (ONE_BIT << TIMER5_ENABLE) | (ONE_BIT << TIMER4_ENABLE)
        | (ONE_BIT << COMPARE4_ENABLE) | (ONE_BIT << COMPARE3_ENABLE);
    localparam ifeb_word_type ENABLES_1_LOW_MASK = (ONE_BIT << EXT_PIN1_ENABLE)
        | (ONE_BIT << CHANGE_NOTIFY_ENABLE) | (ONE_BIT << COMPARATOR_ENABLE)
        | (ONE_BIT << I2C1_MASTER_ENABLE) | (ONE_BIT << I2C1_SLAVE_ENABLE);
    localparam ifeb_word_type ENABLES_1_MASK = ENABLES_1_HIGH_MASK | ENABLES_1_LOW_MASK;
    localparam ifeb_word_type ENABLES_2_MASK = FLAGS_2_MASK;
    localparam ifeb_word_type ENABLES_3_MASK = FLAGS_3_MASK;

endpackage

`default_nettype wire

// *** logic/ifeb_bit_reg.sv ***
`timescale 1ns/1ps
`default_nettype none

// One 16-bit software register whose implemented bits are given by a mask
module ifeb_bit_reg
    import ifeb_pkg::*;
#(
    parameter ifeb_word_type MASK = WORD_ZERO
)
(
    // Clock, reset and freeze
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Software write
    input wire logic wr_en,
    input wire ifeb_word_type wdata,
    // Hardware set requests, one cycle each
    input wire ifeb_word_type set_events,
    // Register contents and the value it takes at the next edge
    output ifeb_word_type value,
    output ifeb_word_type next_value
);

    // Next value: a write replaces the bits, a hardware set is ORed on top so
    // that an event landing in the clearing cycle is never lost
    always_comb
    begin
        next_value = value;
        if (clk_en)
        begin
            if (wr_en)
            begin
                next_value = wdata;
            end
            next_value = (next_value | set_events) & MASK;
        end
    end

    // Register only; the freeze is folded into next_value
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            value <= REG_RESET;
        end
        else
        begin
            value <= next_value;
        end
    end

endmodule

`default_nettype wire

// *** logic/ifeb_bank.sv ***
// Summary of operation
// - Flag reads 1 after request, else 0
// - Enable 1 passes request, 0 blocks it
// - Unassigned bits ignore writes, read zero
// - Enable bank 1 upper byte source layout
// - Enable bank 1 low five bits layout
// - Enable bank 3 source bit layout
// - Flag bank 2 source bit layout
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ifeb_bank
    import ifeb_pkg::*;
(
    // Clock, reset and freeze
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Register port
    input wire ifeb_addr_type reg_addr,
    input wire ifeb_word_type reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output ifeb_word_type reg_rdata,
    // Peripheral event pulses, one bit per source position
    input wire ifeb_word_type event_2,
    input wire ifeb_word_type event_3,
    input wire ifeb_word_type event_4,
    // Flags of banks 0 and 1, held outside this block
    input wire ifeb_word_type flag_in_0,
    input wire ifeb_word_type flag_in_1,
    // Gated requests toward priority arbitration
    output ifeb_word_type request_0,
    output ifeb_word_type request_1,
    output ifeb_word_type request_2,
    output ifeb_word_type request_3,
    // Bank 4 flags; their enables live elsewhere
    output ifeb_word_type flag_out_4
);

    // Implemented-bit mask of the register at an offset, zero when unmapped
    function automatic ifeb_word_type mask_of(input ifeb_addr_type addr);
        ifeb_word_type m;
        m = WORD_ZERO;
        unique case (addr)
            ADDR_FLAGS_2: m = FLAGS_2_MASK;
            ADDR_FLAGS_3: m = FLAGS_3_MASK;
            ADDR_FLAGS_4: m = FLAGS_4_MASK;
            ADDR_ENABLES_0: m = ENABLES_0_MASK;
            ADDR_ENABLES_1: m = ENABLES_1_MASK;
            ADDR_ENABLES_2: m = ENABLES_2_MASK;
            ADDR_ENABLES_3: m = ENABLES_3_MASK;
            default: m = WORD_ZERO;
        endcase
        return m;
    endfunction

    // Register contents and their next values
    ifeb_word_type flags_2, flags_3, flags_4;
    ifeb_word_type next_flags_2, next_flags_3, next_flags_4;
    ifeb_word_type enables_0, enables_1, enables_2, enables_3;
    ifeb_word_type next_enables_0, next_enables_1, next_enables_2, next_enables_3;

    // Write selects, one per register
    logic wr_flags_2, wr_flags_3, wr_flags_4;
    logic wr_enables_0, wr_enables_1, wr_enables_2, wr_enables_3;

    // Registered read data and gated requests
    ifeb_word_type next_reg_rdata;
    ifeb_word_type next_request_0, next_request_1, next_request_2, next_request_3;

    // Address decode for writes; unmapped offsets select nothing
    always_comb
    begin
        wr_flags_2 = reg_wr && (reg_addr == ADDR_FLAGS_2);
        wr_flags_3 = reg_wr && (reg_addr == ADDR_FLAGS_3);
        wr_flags_4 = reg_wr && (reg_addr == ADDR_FLAGS_4);
        wr_enables_0 = reg_wr && (reg_addr == ADDR_ENABLES_0);
        wr_enables_1 = reg_wr && (reg_addr == ADDR_ENABLES_1);
        wr_enables_2 = reg_wr && (reg_addr == ADDR_ENABLES_2);
        wr_enables_3 = reg_wr && (reg_addr == ADDR_ENABLES_3);
    end

    // Flag bank 2: parallel port, compare 5, captures 5..3, serial periph 2
    ifeb_bit_reg #(.MASK(FLAGS_2_MASK)) u_flags_2 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .wr_en(wr_flags_2),
        .wdata(reg_wdata),
        .set_events(event_2),
        .value(flags_2),
        .next_value(next_flags_2)
    );

    // Flag bank 3: calendar alarm, pins 4 and 3, second I2C
    ifeb_bit_reg #(.MASK(FLAGS_3_MASK)) u_flags_3 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .wr_en(wr_flags_3),
        .wdata(reg_wdata),
        .set_events(event_3),
        .value(flags_3),
        .next_value(next_flags_3)
    );

    // Flag bank 4: CRC and UART errors
    ifeb_bit_reg #(.MASK(FLAGS_4_MASK)) u_flags_4 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .wr_en(wr_flags_4),
        .wdata(reg_wdata),
        .set_events(event_4),
        .value(flags_4),
        .next_value(next_flags_4)
    );

    // Enable banks take no hardware sets
    ifeb_bit_reg #(.MASK(ENABLES_0_MASK)) u_enables_0 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .wr_en(wr_enables_0),
        .wdata(reg_wdata),
        .set_events(WORD_ZERO),
        .value(enables_0),
        .next_value(next_enables_0)
    );

    // Enable bank 1: upper byte and low five bits
    ifeb_bit_reg #(.MASK(ENABLES_1_MASK)) u_enables_1 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .wr_en(wr_enables_1),
        .wdata(reg_wdata),
        .set_events(WORD_ZERO),
        .value(enables_1),
        .next_value(next_enables_1)
    );

    // Enable bank 2 mirrors flag bank 2 positions
    ifeb_bit_reg #(.MASK(ENABLES_2_MASK)) u_enables_2 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .wr_en(wr_enables_2),
        .wdata(reg_wdata),
        .set_events(WORD_ZERO),
        .value(enables_2),
        .next_value(next_enables_2)
    );

    // Enable bank 3 mirrors flag bank 3 positions
    ifeb_bit_reg #(.MASK(ENABLES_3_MASK)) u_enables_3 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .wr_en(wr_enables_3),
        .wdata(reg_wdata),
        .set_events(WORD_ZERO),
        .value(enables_3),
        .next_value(next_enables_3)
    );

    // Read mux from current values; request gating built from next values so the registered
    // requests match the registers in the same cycle
    always_comb
    begin
        next_reg_rdata = reg_rdata;
        next_request_0 = request_0;
        next_request_1 = request_1;
        next_request_2 = request_2;
        next_request_3 = request_3;
        if (clk_en)
        begin
            // Read data stand one cycle only; unmapped reads answer zero
            next_reg_rdata = WORD_ZERO;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    ADDR_FLAGS_2: next_reg_rdata = flags_2;
                    ADDR_FLAGS_3: next_reg_rdata = flags_3;
                    ADDR_FLAGS_4: next_reg_rdata = flags_4;
                    ADDR_ENABLES_0: next_reg_rdata = enables_0;
                    ADDR_ENABLES_1: next_reg_rdata = enables_1;
                    ADDR_ENABLES_2: next_reg_rdata = enables_2;
                    ADDR_ENABLES_3: next_reg_rdata = enables_3;
                    default: next_reg_rdata = WORD_ZERO;
                endcase
                next_reg_rdata = next_reg_rdata & mask_of(reg_addr);
            end
            // Outside flags pick up one cycle of latency here
            next_request_0 = flag_in_0 & next_enables_0;
            next_request_1 = flag_in_1 & next_enables_1;
            next_request_2 = next_flags_2 & next_enables_2;
            next_request_3 = next_flags_3 & next_enables_3;
        end
    end

    // Output registers
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            reg_rdata <= REG_RESET;
            request_0 <= REG_RESET;
            request_1 <= REG_RESET;
            request_2 <= REG_RESET;
            request_3 <= REG_RESET;
        end
        else
        begin
            reg_rdata <= next_reg_rdata;
            request_0 <= next_request_0;
            request_1 <= next_request_1;
            request_2 <= next_request_2;
            request_3 <= next_request_3;
        end
    end

    // Bank 4 flags leave directly from their register
    assign flag_out_4 = flags_4;

    // Helper terms that only the checks read
    ifeb_word_type ev2_masked;
    ifeb_word_type ev3_masked;
    ifeb_word_type wd_flags_2;
    ifeb_word_type rd_mask;
    assign ev2_masked = event_2 & FLAGS_2_MASK;
    assign ev3_masked = event_3 & FLAGS_3_MASK;
    assign wd_flags_2 = reg_wdata & FLAGS_2_MASK;
    assign rd_mask = mask_of(reg_addr);

    default clocking ck @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_flag_sets: assert property (
        clk_en && (ev2_masked != WORD_ZERO) |=> (flags_2 & $past(ev2_masked)) == $past(ev2_masked))
        else $error("flag bank 2 missed an event");
    a_flag_clears: assert property (
        clk_en && wr_flags_2 && (event_2 == WORD_ZERO) |=> flags_2 == $past(wd_flags_2))
        else $error("flag bank 2 write not taken");
    a_flag_sticky: assert property (
        !wr_flags_2 |=> (flags_2 & $past(flags_2)) == $past(flags_2))
        else $error("flag dropped without a write");
    a_request_gate: assert property (
        ##1 (request_2 == (flags_2 & enables_2)) && (request_3 == (flags_3 & enables_3)))
        else $error("request differs from flag and enable");
    a_enable_block: assert property (
        clk_en && !wr_enables_0 |=> request_0 == ($past(flag_in_0) & enables_0))
        else $error("enable bank 0 gating wrong");
    // A frozen read leaves the older word standing, so only live reads count
    a_unused_zero: assert property (
        clk_en && reg_rd |=> (reg_rdata & ~$past(rd_mask)) == WORD_ZERO)
        else $error("unused bit read nonzero");
    a_enable1_high: assert property (
        clk_en && wr_enables_1 |=> (enables_1 & ~ENABLES_1_LOW_MASK)
            == ($past(reg_wdata) & ENABLES_1_HIGH_MASK))
        else $error("enable bank 1 upper bits wrong");
    a_enable1_low: assert property (
        clk_en && wr_enables_1 |=> (enables_1 & ~ENABLES_1_HIGH_MASK)
            == ($past(reg_wdata) & ENABLES_1_LOW_MASK))
        else $error("enable bank 1 low bits wrong");
    a_enable3_map: assert property (
        clk_en && wr_enables_3 |=> enables_3 == ($past(reg_wdata) & ENABLES_3_MASK))
        else $error("enable bank 3 layout wrong");
    a_flag2_map: assert property (
        ##1 (flags_2 & ~FLAGS_2_MASK) == WORD_ZERO)
        else $error("flag bank 2 unassigned bit set");
    a_read_once: assert property (
        clk_en && !reg_rd |=> reg_rdata == WORD_ZERO)
        else $error("read data stood too long");

    // Second flag bank and the exported bank follow the same set and read path
    a_flag3_sets: assert property (
        clk_en && (ev3_masked != WORD_ZERO)
            |=> (flags_3 & $past(ev3_masked)) == $past(ev3_masked))
        else $error("flag bank 3 missed an event");
    a_flag4_read: assert property (
        clk_en && reg_rd && (reg_addr == ADDR_FLAGS_4) |=> reg_rdata == $past(flags_4))
        else $error("flag bank 4 read back wrong");
    // Outside flags of bank 1 are gated exactly like bank 0
    a_enable1_gate: assert property (
        clk_en |=> request_1 == ($past(flag_in_1) & enables_1))
        else $error("enable bank 1 gating wrong");
    // A low clock enable must leave registers and read data untouched
    a_freeze_hold: assert property (
        !clk_en |=> (flags_2 == $past(flags_2)) && (enables_0 == $past(enables_0))
            && (reg_rdata == $past(reg_rdata)))
        else $error("state moved while frozen");

    c_event_then_clear: cover property (
        clk_en && (ev2_masked != WORD_ZERO) ##1 wr_flags_2 && clk_en);
    c_set_beats_clear: cover property (clk_en && wr_flags_3 && (event_3 != WORD_ZERO));
    c_request_raised: cover property (request_2 != WORD_ZERO);
    c_frozen_event: cover property (!clk_en && (event_2 != WORD_ZERO));
    c_unmapped_write: cover property (clk_en && reg_wr && (rd_mask == WORD_ZERO));

endmodule

`default_nettype wire

// *** verification/ifeb_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Far side: peripheral event sources and the flag levels of banks 0 and 1
module ifeb_src_model
    import ifeb_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Bench wishes for the next cycle
    input wire logic fire,
    input wire ifeb_word_type want_0,
    input wire ifeb_word_type want_1,
    input wire ifeb_word_type want_2,
    input wire ifeb_word_type want_3,
    input wire ifeb_word_type want_4,
    // Toward the block
    output ifeb_word_type event_2,
    output ifeb_word_type event_3,
    output ifeb_word_type event_4,
    output ifeb_word_type flag_in_0,
    output ifeb_word_type flag_in_1
);
    // Events are registered each cycle from the wishes; a line stays high only while fire stays set.
    // Lines are unknown before the first edge, which falls inside reset.
    always @(posedge sys_clk)
    begin
        event_2 <= fire ? want_2 : 16'h0000;
        event_3 <= fire ? want_3 : 16'h0000;
        event_4 <= fire ? want_4 : 16'h0000;
        // Outside flags are levels that may change every cycle
        flag_in_0 <= want_0;
        flag_in_1 <= want_1;
    end
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import ifeb_pkg::*;

    // Clock, reset and freeze
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    // Register port
    ifeb_addr_type reg_addr = 3'h0;
    ifeb_word_type reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    ifeb_word_type reg_rdata, request_0, request_1, request_2, request_3, flag_out_4;
    // Partner side
    ifeb_word_type event_2, event_3, event_4, flag_in_0, flag_in_1;
    logic fire = 1'b0;
    ifeb_word_type want_0 = 16'h0000;
    ifeb_word_type want_1 = 16'h0000;
    ifeb_word_type want_2 = 16'h0000;
    ifeb_word_type want_3 = 16'h0000;
    ifeb_word_type want_4 = 16'h0000;
    // Bookkeeping
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [15:0] lfsr = 16'h002d;
    // Implemented bits per offset, written out by hand from the bit layouts
    ifeb_word_type mask [8];
    // Reference registers, expected requests and expected read data
    ifeb_word_type m [8];
    ifeb_word_type er [4];
    ifeb_word_type exp_q [$];
    logic rd_taken = 1'b0;
    logic live = 1'b1;

    always #2 sys_clk = ~sys_clk;

    ifeb_bank DUT (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .event_2(event_2), .event_3(event_3), .event_4(event_4),
        .flag_in_0(flag_in_0), .flag_in_1(flag_in_1), .request_0(request_0),
        .request_1(request_1), .request_2(request_2), .request_3(request_3),
        .flag_out_4(flag_out_4));

    ifeb_src_model src (.sys_clk(sys_clk), .fire(fire), .want_0(want_0), .want_1(want_1),
        .want_2(want_2), .want_3(want_3), .want_4(want_4), .event_2(event_2),
        .event_3(event_3), .event_4(event_4), .flag_in_0(flag_in_0), .flag_in_1(flag_in_1));

    initial
    begin
        mask[0] = 16'h22e3;
        mask[1] = 16'h4066;
        mask[2] = 16'h000e;
        mask[3] = 16'h3fef;
        mask[4] = 16'hfe1f;
        mask[5] = 16'h22e3;
        mask[6] = 16'h4066;
        mask[7] = 16'h0000;
    end

    // Pseudo-random source, shifted once per call
    function automatic ifeb_word_type rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // One comparison, counted; mismatches are reported at once
    task automatic check(input ifeb_word_type seen, input ifeb_word_type want);
        samples_checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
        end
    endtask

    // One bus cycle; every input is assigned exactly once per edge
    task automatic step(input logic wr, input logic rd, input ifeb_addr_type a,
        input ifeb_word_type d, input logic ce, input ifeb_word_type w);
        reg_wr <= wr;
        reg_rd <= rd;
        reg_addr <= a;
        reg_wdata <= d;
        clk_en <= ce;
        fire <= (w != 16'h0000);
        want_2 <= w;
        want_3 <= {w[7:0], w[15:8]};
        want_4 <= w >> 1;
        want_0 <= rnd();
        want_1 <= rnd();
        @(posedge sys_clk);
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Reference model; reads pre-edge inputs because the bench drives by NBA
    always @(posedge sys_clk)
    begin
        rd_taken = 1'b0;
        live = clk_en || !reset_n;
        if (!reset_n)
        begin
            foreach (m[i]) m[i] = 16'h0000;
            foreach (er[i]) er[i] = 16'h0000;
        end
        else if (clk_en)
        begin
            // Reads see the value before this edge's updates
            if (reg_rd)
            begin
                exp_q.push_back(m[reg_addr]);
                rd_taken = 1'b1;
            end
            if (reg_wr)
                m[reg_addr] = reg_wdata & mask[reg_addr];
            // Set wins over a clearing write in the same cycle
            m[0] = m[0] | (event_2 & mask[0]);
            m[1] = m[1] | (event_3 & mask[1]);
            m[2] = m[2] | (event_4 & mask[2]);
            er[0] = flag_in_0 & m[3];
            er[1] = flag_in_1 & m[4];
            er[2] = m[0] & m[5];
            er[3] = m[1] & m[6];
        end
    end

    // Output watcher, sampling where everything has settled
    always @(negedge sys_clk)
    begin
        if (rd_taken)
            check(reg_rdata, exp_q.pop_front());
        else if (live)
            check(reg_rdata, 16'h0000);
        check(request_0, er[0]);
        check(request_1, er[1]);
        check(request_2, er[2]);
        check(request_3, er[3]);
        check(flag_out_4, m[2]);
    end

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Reset values, then all ones everywhere including the unmapped offset
        for (int a = 0; a < 8; a++)
            step(1'b0, 1'b1, 3'(a), 16'h0000, 1'b1, 16'h0000);
        for (int a = 0; a < 8; a++)
        begin
            step(1'b1, 1'b0, 3'(a), 16'hffff, 1'b1, 16'h0000);
            step(1'b0, 1'b1, 3'(a), 16'h0000, 1'b1, 16'h0000);
        end
        // Single source walk: set, stick, clear with zero, read back
        step(1'b1, 1'b0, ADDR_FLAGS_2, 16'h0000, 1'b1, 16'h0000);
        step(1'b0, 1'b0, 3'h0, 16'h0000, 1'b1, ONE_BIT << PARALLEL_PORT_FLAG);
        repeat (4) step(1'b0, 1'b1, ADDR_FLAGS_2, 16'h0000, 1'b1, 16'h0000);
        step(1'b1, 1'b0, ADDR_FLAGS_2, 16'h0000, 1'b1, 16'h0000);
        step(1'b0, 1'b1, ADDR_FLAGS_2, 16'h0000, 1'b1, 16'h0000);
        // Random traffic: writes, reads, events, freezes, set against clear
        repeat (3000)
        begin
            automatic ifeb_word_type r = rnd();
            automatic ifeb_word_type w = (r[9:8] == 2'b00) ? (rnd() & rnd()) : 16'h0000;
            step(r[1:0] == 2'b00, r[1:0] == 2'b01, r[4:2], rnd(), r[7:5] != 3'b000, w);
        end
        // Second reset in mid-run, with traffic frozen, then everything reads zero
        reset_n <= 1'b0;
        repeat (3) step(1'b0, 1'b0, 3'h0, 16'h0000, 1'b0, 16'h0000);
        reset_n <= 1'b1;
        for (int a = 0; a < 8; a++)
            step(1'b0, 1'b1, 3'(a), 16'h0000, 1'b1, 16'h0000);
        repeat (3) step(1'b0, 1'b0, 3'h0, 16'h0000, 1'b1, 16'h0000);
        print_verdict();
    end
endmodule

`default_nettype wire
